// ===== logic/bc4_crc_ctrl.sv
`timescale 1ns/1ps
// Purpose: controller end: sends a bc4 write burst with its crc beat
// Assumes: one burst at a time, fixed bc4 chop
// Notes:   tree image built the same way as the device so crcs agree
module bc4_crc_ctrl
   import bc4_crc_pkg::*;
#(
   parameter int GROUPS = 1
)(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   input  wire logic                   i_start,
   input  wire logic                   i_a2,
   input  wire logic                   i_mask_en,
   input  wire logic [32*GROUPS-1:0]   i_data,
   input  wire logic [4*GROUPS-1:0]    i_mask,
   output logic                        o_busy,
   bc4_crc_if.ctrl                     link
);
   import bc4_crc_pkg::*;

   logic [3:0]                 beat_q,  beat_d;
   logic                       busy_q,  busy_d;
   logic                       a2_q;
   logic [32*GROUPS-1:0]       data_q;
   logic [4*GROUPS-1:0]        mask_q;
   logic [8*GROUPS-1:0]        crc_q;
   logic [TREE_BITS*GROUPS-1:0] tree;
   logic [8*GROUPS-1:0]        crc_w;
   logic [8*GROUPS-1:0]        dq_w;
   logic [GROUPS-1:0]          dm_w;

   ////////////////////////////////////////////////////////////////////
   // tree image and crc per group, mirroring the device mapping
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_grp
      for (genvar n = 0; n < 9; n++)
      begin : g_lane
         logic [3:0] nib;
         assign nib = (n == 8) ? (i_mask_en ? i_mask[4*g +: 4] : 4'hf)
                               : i_data[32*g + 4*n +: 4];
         assign tree[TREE_BITS*g + 8*n +: 8] = i_a2 ? {nib, 4'hf} : {4'hf, nib};
      end
      assign crc_w[8*g +: 8] = crc8_72(tree[TREE_BITS*g +: TREE_BITS]);
      for (genvar n = 0; n < 8; n++)
      begin : g_dq
         assign dq_w[8*g + n] = (beat_q < 4'(DATA_BEATS)) ? data_q[32*g + 4*n + beat_q[1:0]]
                              : (beat_q == 4'(CRC_BEAT)) ? crc_q[8*g + n]
                              : 1'b1;
      end
      assign dm_w[g] = (beat_q < 4'(DATA_BEATS)) ? mask_q[4*g + beat_q[1:0]] : 1'b1;
   end

   assign busy_d = i_start & ~busy_q ? 1'b1
                 : (beat_q == 4'(BURST_BEATS - 1)) ? 1'b0 : busy_q;
   assign beat_d = busy_q ? beat_q + 4'h1 : 4'h0;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         busy_q <= 1'b0;
         beat_q <= 4'h0;
         a2_q   <= 1'b0;
         data_q <= '0;
         mask_q <= '0;
         crc_q  <= '0;
      end
      else
      begin
         busy_q <= busy_d;
         beat_q <= busy_d & busy_q ? beat_d : 4'h0;
         if (i_start & ~busy_q)
         begin
            a2_q   <= i_a2;
            data_q <= i_data;
            mask_q <= i_mask_en ? i_mask : '1;
            crc_q  <= crc_w;
         end
      end
   end

   assign link.beat_valid = busy_q;
   assign link.a2         = a2_q;
   assign link.dq         = busy_q ? dq_w : '1;
   assign link.dm         = busy_q ? dm_w : '1;
   assign o_busy          = busy_q;
endmodule // bc4_crc_ctrl

// ===== logic/bc4_crc_dev.sv
`timescale 1ns/1ps
// Purpose: device end: rebuilds bc4 crc tree inputs and checks crc
// Assumes: beat_valid high for exactly ten consecutive beats
// Notes:   groups = 2 gives the x16 pair of identical trees
module bc4_crc_dev
   import bc4_crc_pkg::*;
#(
   parameter int GROUPS = 1
)(
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_rst,
   input  wire logic                      i_mask_en,
   input  wire logic                      i_err_clear,
   output logic                           o_crc_err,
   output logic                           o_check_pulse,
   output logic [TREE_BITS*GROUPS-1:0]    o_tree,
   output logic [8*GROUPS-1:0]            o_crc_rx,
   bc4_crc_if.dev                         link
);
   import bc4_crc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // local widths, all derived from the group count
   localparam int DATA_BITS = 32*GROUPS;
   localparam int MASK_BITS = 4*GROUPS;
   localparam int CRC_BITS  = 8*GROUPS;
   localparam int TREE_ALL  = TREE_BITS*GROUPS;

   ////////////////////////////////////////////////////////////////////
   // beat sequencing
   logic [3:0]           beat_q;
   logic [3:0]           beat_d;
   logic                 first_beat;
   logic                 data_beat;
   logic                 crc_beat;
   logic                 last_beat;
   logic [1:0]           slot;

   ////////////////////////////////////////////////////////////////////
   // captured burst
   logic                 a2_q;
   logic                 a2_d;
   logic [DATA_BITS-1:0] data_q;
   logic [DATA_BITS-1:0] data_d;
   logic [MASK_BITS-1:0] mask_q;
   logic [MASK_BITS-1:0] mask_d;
   logic [CRC_BITS-1:0]  crc_rx_q;
   logic [CRC_BITS-1:0]  crc_rx_d;

   ////////////////////////////////////////////////////////////////////
   // tree image, check and status
   logic [TREE_ALL-1:0]  tree_w;
   logic [TREE_ALL-1:0]  tree_q;
   logic [TREE_ALL-1:0]  tree_d;
   logic [CRC_BITS-1:0]  crc_calc;
   logic                 mismatch;
   logic                 check_q;
   logic                 err_q;
   logic                 err_d;

   ////////////////////////////////////////////////////////////////////
   // places one lane's four beats in its tree byte; the unused half is one
   function automatic logic [7:0] place_nib(input logic hi, input logic [3:0] nib);
      logic [7:0] byte_v;
      byte_v = hi ? {nib, 4'hf} : {4'hf, nib};
      return byte_v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // beat decode: beats 0-3 data, beat 8 crc; beats 4-7 and 9 ignored
   assign first_beat = link.beat_valid & (beat_q == 4'h0);
   assign data_beat  = link.beat_valid & (beat_q < 4'(DATA_BEATS));
   assign crc_beat   = link.beat_valid & (beat_q == 4'(CRC_BEAT));
   assign last_beat  = link.beat_valid & (beat_q == 4'(BURST_BEATS - 1));
   assign slot       = beat_q[1:0];
   // a gap in beat_valid restarts the count, so a cut burst never checks
   assign beat_d     = (link.beat_valid & ~last_beat) ? beat_q + 4'h1 : 4'h0;

   // a2 is only looked at on the first beat: the chop setting is fixed
   assign a2_d       = first_beat ? link.a2 : a2_q;
   assign crc_rx_d   = crc_beat ? link.dq : crc_rx_q;

   ////////////////////////////////////////////////////////////////////
   // capture of data and mask beats, one bit at a time
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_cap
      for (genvar b = 0; b < DATA_BEATS; b++)
      begin : g_beat
         logic take;
         assign take = data_beat & (slot == 2'(b));
         for (genvar n = 0; n < LANES_PER_GROUP; n++)
         begin : g_bit
            assign data_d[32*g + 4*n + b] = take ? link.dq[8*g + n]
                                                 : data_q[32*g + 4*n + b];
         end
         // the mask lane is kept raw; whether it counts is decided at assembly
         assign mask_d[4*g + b] = take ? link.dm[g] : mask_q[4*g + b];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // tree assembly: 36 real bits per group, all others forced to one
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_grp
      for (genvar n = 0; n < LANES_PER_GROUP + 1; n++)
      begin : g_lane
         logic [3:0] nib;
         // mask lane counts only when masking or inversion is on
         assign nib = (n == LANES_PER_GROUP)
                    ? (i_mask_en ? mask_q[4*g +: 4] : 4'hf)
                    : data_q[32*g + 4*n +: 4];
         assign tree_w[TREE_BITS*g + 8*n +: 8] = place_nib(a2_q, nib);
      end
      // each group owns an identical tree over its own 72 bits
      assign crc_calc[8*g +: 8] = crc8_72(tree_w[TREE_BITS*g +: TREE_BITS]);
   end
   // untouched tree positions come out of place_nib as ones

   ////////////////////////////////////////////////////////////////////
   // check on the last beat, when the crc beat is already held
   assign mismatch = last_beat & (crc_calc != crc_rx_q);
   assign tree_d   = last_beat ? tree_w : tree_q;
   // a new error wins over a clear in the same cycle
   assign err_d    = mismatch | (err_q & ~i_err_clear);

   ////////////////////////////////////////////////////////////////////
   // sequencing register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         beat_q <= 4'h0;
      else
         beat_q <= beat_d;
   end

   ////////////////////////////////////////////////////////////////////
   // capture registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         a2_q     <= 1'b0;
         data_q   <= '0;
         mask_q   <= '0;
         crc_rx_q <= '0;
      end
      else
      begin
         a2_q     <= a2_d;
         data_q   <= data_d;
         mask_q   <= mask_d;
         crc_rx_q <= crc_rx_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status registers; the tree reads all ones until the first check
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         err_q   <= 1'b0;
         check_q <= 1'b0;
         tree_q  <= '1;
      end
      else
      begin
         err_q   <= err_d;
         check_q <= last_beat;
         tree_q  <= tree_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign o_crc_err     = err_q;
   assign o_check_pulse = check_q;
   assign o_tree        = tree_q;
   assign o_crc_rx      = crc_rx_q;
endmodule // bc4_crc_dev

// ===== logic/bc4_crc_if.sv
`timescale 1ns/1ps
// Purpose: link between controller and device for bc4 crc writes
// Assumes: groups = 1 for x8, 2 for x16
// Notes:   beat_valid marks each of the ten beats
interface bc4_crc_if #(parameter int GROUPS = 1);
   logic                  beat_valid;
   logic                  a2;
   logic [8*GROUPS-1:0]   dq;
   logic [GROUPS-1:0]     dm;
   modport ctrl (output beat_valid, output a2, output dq, output dm);
   modport dev  (input beat_valid, input a2, input dq, input dm);
endinterface // bc4_crc_if

// ===== logic/bc4_crc_pkg.sv
// Purpose: shared constants for the burst-chop-4 write crc link
// Assumes: one beat of the data bus per clock, ten beats per burst
// Notes:   lane group = 8 data lanes plus one mask/inversion lane
//
// Behaviour
// - x8 tree has 36 real inputs, rest ones
// - a2 low: lanes carry beats 0-3, crc beat 8
// - mask lane drives ones in beats 8, 9
// - a2 low: mask bits 64-67 used or ones
// - a2 high: beats land in upper nibble positions
// - a2 high: mask bits 68-71 used or ones
// - x16 has two identical 36-input trees
// - x16 upper lanes from bit 72, crc 8-15
// - x16 a2 low: bits 136-139 from upper mask
// - x16 a2 high: upper lanes bits 76 to 135
// - x16 a2 high: bits 140-143 from upper mask
// - fixed chop only; a2 picks half sent
// - lower tree crc 0-7, upper crc 8-15
// - crc mismatch sets sticky error until cleared
package bc4_crc_pkg;
   localparam int LANES_PER_GROUP = 8;
   localparam int TREE_BITS       = 72;
   localparam int BURST_BEATS     = 10;
   localparam int CRC_BEAT        = 8;
   localparam int DATA_BEATS      = 4;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'hff;

   // crc8 over a 72-bit vector, bit 0 first
   function automatic logic [7:0] crc8_72(input logic [TREE_BITS-1:0] d);
      logic [7:0] c;
      logic       fb;
      c = CRC_INIT;
      for (int i = 0; i < TREE_BITS; i++)
      begin
         fb = c[7] ^ d[i];
         c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction
endpackage

// ===== verification/bc4_crc_chk.sv
`timescale 1ns/1ps
// Purpose: properties of the bc4 crc link and device outputs
// Assumes: x16 pairing, beats counted here
// Notes:   plain inputs, no bind
module bc4_crc_chk
   import bc4_crc_pkg::*;
#(parameter int GROUPS = 2)(
   input wire logic                        i_ref_clk,
   input wire logic                        i_rst,
   input wire logic                        beat_valid,
   input wire logic                        a2,
   input wire logic [8*GROUPS-1:0]         dq,
   input wire logic [GROUPS-1:0]           dm,
   input wire logic                        i_mask_en,
   input wire logic                        i_err_clear,
   input wire logic                        o_crc_err,
   input wire logic                        o_check_pulse,
   input wire logic [TREE_BITS*GROUPS-1:0] o_tree,
   input wire logic [8*GROUPS-1:0]         o_crc_rx
);
   localparam logic [TREE_BITS*GROUPS-1:0] HI  = {9*GROUPS{8'hf0}};
   localparam logic [TREE_BITS*GROUPS-1:0] DMB = {GROUPS{8'hff, 64'h0}};
   logic [3:0]          idx_q;
   logic                a2_q;
   logic [8*GROUPS-1:0] crc_q;
   // mask enable as the device saw it on the last beat; the bench may move it right after
   logic                men_q;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst) idx_q <= 4'h0;
      else if (beat_valid) idx_q <= (idx_q == 4'h9) ? 4'h0 : idx_q + 4'h1;
      if (beat_valid && idx_q == 4'h0) a2_q <= a2;
      if (beat_valid && idx_q == 4'h8) crc_q <= dq;
      if (beat_valid && idx_q == 4'h9) men_q <= i_mask_en;
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   property p_len; $rose(beat_valid) |-> beat_valid[*8] ##1 beat_valid[*2]; endproperty
   property p_ones; beat_valid && idx_q inside {[4:7], 9} |-> &dq; endproperty
   property p_dm; beat_valid && idx_q >= 4'h8 |-> &dm; endproperty
   property p_chk; beat_valid && idx_q == 4'h9 |=> o_check_pulse; endproperty
   property p_rx; o_check_pulse |-> o_crc_rx == crc_q; endproperty
   property p_nib;
      o_check_pulse |-> (o_tree & (a2_q ? ~HI : HI)) == (a2_q ? ~HI : HI);
   endproperty
   property p_dmoff; o_check_pulse && !men_q |-> (o_tree & DMB) == DMB; endproperty
   property p_stick; o_crc_err && !i_err_clear |=> o_crc_err; endproperty
   property p_set; $rose(o_crc_err) |-> o_check_pulse; endproperty
   a_len: assert property (p_len) else $error("burst length wrong");
   a_ones: assert property (p_ones) else $error("idle beat not ones");
   a_dm: assert property (p_dm) else $error("mask lane not ones");
   a_chk: assert property (p_chk) else $error("no check pulse");
   a_rx: assert property (p_rx) else $error("crc beat lost");
   a_nib: assert property (p_nib) else $error("wrong nibble used");
   a_dmoff: assert property (p_dmoff) else $error("mask bits not ones");
   a_stick: assert property (p_stick) else $error("error flag dropped");
   a_set: assert property (p_set) else $error("error flag set early");
   c_a2: cover property (o_check_pulse && a2_q);
   c_err: cover property ($rose(o_crc_err));
   c_clr: cover property (o_crc_err ##1 !o_crc_err);
endmodule // bc4_crc_chk

// ===== verification/test_write_crc_bc4_input_mapper.sv
`timescale 1ns/1ps
// Purpose: x16 bc4 crc link, controller facing device
// Assumes: ends share mask enable except in the mismatch case
// Notes:   a mask-enable mismatch stands in for a corrupted burst
module test_write_crc_bc4_input_mapper;
   logic clk = 0, rst = 1, start = 0, a2_s = 0, men_c = 0, men_d = 0, clear = 0, busy, err_m = 0;
   logic [63:0]  dat = '0;
   logic [7:0]   msk = '0;
   logic         o_crc_err, o_check_pulse;
   logic [143:0] o_tree, q_tree[$];
   logic [15:0]  o_crc_rx;
   logic         q_err[$];
   int           bad_count = 0, checks = 0;
   always #4 clk = ~clk;
   bc4_crc_if #(.GROUPS(2)) lk ();
   bc4_crc_ctrl #(.GROUPS(2)) bc4_crc_ctrl_i (.i_ref_clk(clk), .i_rst(rst), .i_start(start),
      .i_a2(a2_s), .i_mask_en(men_c), .i_data(dat), .i_mask(msk), .o_busy(busy), .link(lk));
   bc4_crc_dev #(.GROUPS(2)) bc4_crc_dev_i (.i_ref_clk(clk), .i_rst(rst), .i_mask_en(men_d),
      .i_err_clear(clear), .o_crc_err(o_crc_err), .o_check_pulse(o_check_pulse),
      .o_tree(o_tree), .o_crc_rx(o_crc_rx), .link(lk));
   bc4_crc_chk #(.GROUPS(2)) bc4_crc_chk_i (.i_ref_clk(clk), .i_rst(rst),
      .beat_valid(lk.beat_valid), .a2(lk.a2), .dq(lk.dq), .dm(lk.dm), .i_mask_en(men_d),
      .i_err_clear(clear), .o_crc_err(o_crc_err), .o_check_pulse(o_check_pulse),
      .o_tree(o_tree), .o_crc_rx(o_crc_rx));
   ////////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      if (bad_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [143:0] e, input logic [143:0] s);
      checks++;
      if (e !== s)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   // undriven tree inputs stay one, lane 8 of a group is the mask lane
   function automatic logic [143:0] tree(logic a, logic m, logic [63:0] d, logic [7:0] k);
      logic [143:0] t;
      t = '1;
      for (int g = 0; g < 2; g++)
         for (int n = 0; n < 9; n++)
            for (int b = 0; b < 4; b++)
               t[72*g+8*n+4*a+b] = (n < 8) ? d[32*g+4*n+b] : (m ? k[4*g+b] : 1'b1);
      return t;
   endfunction
   task automatic burst(input logic a, input logic mc, input logic md, input int gap);
      logic [143:0] tc, td;
      dat = {$urandom, $urandom};
      msk = 8'($urandom) & 8'h77;
      tc = tree(a, mc, dat, msk);
      td = tree(a, md, dat, msk);
      err_m = err_m | (tc !== td);
      q_tree.push_back(td);
      q_err.push_back(err_m);
      a2_s = a;
      men_c = mc;
      men_d = md;
      start = 1'b1;
      tick;
      start = 1'b0;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) tick;
      if (busy !== 1'b0)
      begin
         bad_count++;
         tally_and_finish;
      end
      repeat (gap) tick;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
      if (o_check_pulse === 1'b1)
      begin
         if (q_tree.size() == 0) chk("unexpected check", 0, 1);
         else
         begin
            chk("tree", q_tree.pop_front(), o_tree);
            chk("crc_err", q_err.pop_front(), o_crc_err);
         end
      end
   initial
   begin
      void'($urandom(32'ha1309e38));
      repeat (2) @(posedge clk);
      #1 rst = 0;
      chk("tree after reset", '1, o_tree);
      for (int i = 0; i < 4; i++) burst(i[0], i[1], i[1], 2);
      repeat (6) burst(1'($urandom), 1, 1, 0);
      burst(0, 1, 0, 2);
      burst(1, 1, 1, 2);
      clear = 1;
      tick;
      clear = 0;
      err_m = 0;
      chk("crc_err cleared", 0, o_crc_err);
      burst(0, 0, 0, 2);
      for (int i = 0; i < 50 && q_tree.size() > 0; i++) tick;
      if (q_tree.size() > 0) bad_count++;
      tally_and_finish;
   end
endmodule // test_write_crc_bc4_input_mapper
